// *** verilog/nov_stage.v ***
// Neutral overvoltage pick-up stage with Avalon-MM register slave.
`include "nov_consts.vh"

module nov_stage #(
	parameter STEP_CYC = `NOV_STEP_CYC // Cycles per 5 ms step.
) (
	input  wire        core_clk,        // System clock.
	input  wire        rst,             // Synchronous reset.
	input  wire        clk_en,          // Freezes all state when low.
	input  wire [5:0]  avm_address,     // Byte address.
	input  wire        avm_read,        // Read request.
	input  wire        avm_write,       // Write request.
	input  wire [31:0] avm_writedata,   // Write data.
	output reg  [31:0] avm_readdata,    // Read data.
	output reg         avm_waitrequest, // Low for one cycle to answer.
	input  wire        cycle_strobe,    // Start of a processing cycle.
	input  wire [15:0] ul1_mag,         // Phase 1 fundamental, 0.01 V.
	input  wire [15:0] ul2_mag,         // Phase 2 fundamental, 0.01 V.
	input  wire [15:0] ul3_mag,         // Phase 3 fundamental, 0.01 V.
	input  wire [15:0] ch3_mag,         // Third channel, 0.01 percent.
	input  wire [15:0] ch4_mag,         // Fourth channel, 0.01 percent.
	input  wire        ch3_resid_mode,  // Third channel is residual.
	input  wire        ch4_resid_mode,  // Fourth channel is residual.
	input  wire        ln_connected,    // Line-to-neutral inputs wired.
	input  wire        force_enable,    // Global stage forcing enable.
	input  wire        group_sel,       // Active setting group.
	input  wire        block_in,        // Blocking matrix input.
	output reg  [1:0]  stage_state,     // Normal, start, trip, blocked.
	output reg         start_out,       // Start condition for timers.
	output reg         trip_out,        // Trip indication.
	output reg         blocked_out      // Blocked indication.
);

	// ==========================================================
	// Local encodings.
	localparam [1:0] ST_NORMAL  = 2'h0; // Stage idle.
	localparam [1:0] ST_START   = 2'h1; // Picked up, timing.
	localparam [1:0] ST_TRIP    = 2'h2; // Operating time elapsed.
	localparam [1:0] ST_BLOCKED = 2'h3; // Picked up while blocked.
	localparam [1:0] SRC_NONE   = 2'h0; // Residual unavailable.
	localparam [1:0] SRC_CALC   = 2'h1; // Computed residual.
	localparam [1:0] SRC_CH3    = 2'h2; // Third channel.
	localparam [1:0] SRC_CH4    = 2'h3; // Fourth channel.
	localparam [1:0] DV_IDLE    = 2'h0; // Divider idle.
	localparam [1:0] DV_RATIO   = 2'h1; // Dividing for the ratio.
	localparam [1:0] DV_TIME    = 2'h2; // Dividing for inverse time.

	// ==========================================================
	// Registers.
	reg  [1:0]  src_sel_reg;   // Static source selection.
	reg  [1:0]  force_reg;     // Static forced status.
	reg  [13:0] thr_reg [0:1]; // Per-group threshold, 0.01 percent.
	reg  [16:0] tim_reg [0:1]; // Per-group delay or dial, INVERSE_TIME_MODE flag.
	reg  [16:0] meas_reg;      // Latched measured value.
	reg         pickup_reg;    // Comparator state with hysteresis.
	reg         block_reg;     // Block input sampled this cycle.
	reg  [16:0] ratio_reg;     // Measured over threshold, 0.01 steps.
	reg  [18:0] expt_reg;      // Expected operating time, 5 ms steps.
	reg  [18:0] elap_reg;      // Elapsed start time, 5 ms steps.
	reg  [15:0] tick_reg;      // Cycle counter for 5 ms steps.
	reg  [1:0]  dv_state_reg;  // Divider sequence state.
	reg  [5:0]  dv_cnt_reg;    // Divider step counter.
	reg  [31:0] dv_num_reg;    // Dividend being shifted out.
	reg  [31:0] dv_den_reg;    // Divisor.
	reg  [31:0] dv_rem_reg;    // Partial remainder.
	reg  [31:0] dv_quo_reg;    // Quotient being built.

	// ==========================================================
	// Combinational terms.
	wire [13:0] thr_act = thr_reg[group_sel];
	wire [16:0] tim_act = tim_reg[group_sel];
	wire        inverse_time_mode    = tim_act[`NOV_TIM_INVERSE_TIME_MODE_BIT];
	wire [17:0] ph_sum  = {2'h0, ul1_mag} + {2'h0, ul2_mag}
	                    + {2'h0, ul3_mag};
	wire [33:0] calc_p  = ph_sum * `NOV_CALC_SCALE;
	wire [16:0] calc_pct = calc_p[32:16];
	wire [19:0] rem_time = {1'b0, expt_reg} - {1'b0, elap_reg};
	wire        req      = avm_read | avm_write;
	wire        take_wr  = avm_write & ~avm_waitrequest;
	wire [31:0] rem_sh   = {dv_rem_reg[30:0], dv_num_reg[31]};
	wire [23:0] m100     = meas_reg * `NOV_HUNDRED;
	wire [23:0] t97      = thr_act * `NOV_REL_PCT;
	// Scaled sample for the ratio dividend. It is sized here, because a
	// product inside a concatenation would keep only seventeen bits.
	wire [23:0] mn100    = meas_next * `NOV_HUNDRED;
	wire [31:0] wd       = avm_writedata;
	wire [13:0] wthr     = (wd[13:0] < `NOV_THR_MIN) ? `NOV_THR_MIN :
	                       (wd[13:0] > `NOV_THR_MAX) ? `NOV_THR_MAX :
	                       wd[13:0];

	reg  [1:0]  src_act;   // Active source for this cycle.
	reg  [16:0] meas_next; // Magnitude of the active source.
	reg         pickup_next;
	reg  [1:0]  state_next;

	// ==========================================================
	// Source resolution. Inputs are fundamental magnitudes only.
	// A channel counts only while it is in residual mode.
	always @* begin
		case (src_sel_reg)
			SRC_CALC: src_act = ln_connected ? SRC_CALC : SRC_NONE;
			SRC_CH3:  src_act = ch3_resid_mode ? SRC_CH3 : SRC_NONE;
			SRC_CH4:  src_act = ch4_resid_mode ? SRC_CH4 : SRC_NONE;
			default: begin
				// Nothing chosen: computed residual if phases exist.
				if (ln_connected) begin
					src_act = SRC_CALC;
				end else if (ch3_resid_mode) begin
					src_act = SRC_CH3;
				end else if (ch4_resid_mode) begin
					src_act = SRC_CH4;
				end else begin
					src_act = SRC_NONE;
				end
			end
		endcase
		case (src_act)
			// One third of the phase sum, scaled so 57.74 V is 100 %.
			SRC_CALC: meas_next = calc_pct;
			SRC_CH3:  meas_next = {1'b0, ch3_mag};
			SRC_CH4:  meas_next = {1'b0, ch4_mag};
			default:  meas_next = 17'h00000;
		endcase
	end

	// ==========================================================
	// Comparator with built-in 97 percent reset ratio. It looks at the
	// sample latched on the previous strobe, so a step at the input
	// shows in the pick-up state two strobes later. The release test
	// scales both sides by a hundred to stay in whole numbers.
	always @* begin
		if (pickup_reg) begin
			pickup_next = (m100 >= t97);
		end else begin
			pickup_next = (meas_reg > {3'h0, thr_act});
		end
	end

	// ==========================================================
	// Stage output. Forcing overrides only with global enable.
	// Blocking wins over trip: a stage that was already timing drops
	// back to blocked, and its elapsed time clears with start.
	always @* begin
		if (force_enable && force_reg != ST_NORMAL) begin
			state_next = force_reg;
		end else if (!pickup_reg) begin
			state_next = ST_NORMAL;
		end else if (block_reg) begin
			state_next = ST_BLOCKED;
		end else if (rem_time[19] || rem_time == 20'h00000) begin
			state_next = ST_TRIP;
		end else begin
			state_next = ST_START;
		end
	end

	// ==========================================================
	// Avalon slave: waitrequest drops for one cycle after a request
	// is seen, so every access completes on the second edge.
	// While the clock enable is low the handshake freezes as well,
	// so a master sees a longer wait, but a write answered in that cycle is dropped.
	always @(posedge core_clk) begin
		if (rst) begin
			avm_waitrequest <= 1'b1;
			avm_readdata    <= 32'h00000000;
		end else if (clk_en) begin
			avm_waitrequest <= ~(req & avm_waitrequest);
			if (avm_read && avm_waitrequest) begin
				case (avm_address)
					`NOV_CTRL_OFS:  avm_readdata <= {28'h0, force_reg,
					                                 src_sel_reg};
					`NOV_THR0_OFS:  avm_readdata <= {18'h0, thr_reg[0]};
					`NOV_TIM0_OFS:  avm_readdata <= {15'h0, tim_reg[0]};
					`NOV_THR1_OFS:  avm_readdata <= {18'h0, thr_reg[1]};
					`NOV_TIM1_OFS:  avm_readdata <= {15'h0, tim_reg[1]};
					`NOV_STAT_OFS:  avm_readdata <= {26'h0, block_reg,
					                   stage_state, pickup_reg,
					                   src_act};
					`NOV_RATIO_OFS: avm_readdata <= {15'h0, ratio_reg};
					`NOV_EXPT_OFS:  avm_readdata <= {13'h0, expt_reg};
					`NOV_TREM_OFS:  avm_readdata <= {{12{rem_time[19]}},
					                                 rem_time};
					default:        avm_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Setting registers. Source and force are static and sit apart
	// from the two group banks, which the group input selects live.
	// Threshold writes are clamped rather than refused, so software
	// always reads back the value that the comparator really uses.
	always @(posedge core_clk) begin
		if (rst) begin
			src_sel_reg <= SRC_NONE;
			force_reg   <= ST_NORMAL;
			thr_reg[0]  <= `NOV_THR_RST;
			thr_reg[1]  <= `NOV_THR_RST;
			tim_reg[0]  <= `NOV_TIM_RST;
			tim_reg[1]  <= `NOV_TIM_RST;
		end else if (clk_en && take_wr) begin
			case (avm_address)
				`NOV_CTRL_OFS: begin
					// A channel choice is refused unless it is residual.
					if ((wd[1:0] != SRC_CH3 || ch3_resid_mode) &&
					    (wd[1:0] != SRC_CH4 || ch4_resid_mode)) begin
						src_sel_reg <= wd[1:0];
					end
					force_reg <= wd[3:2];
				end
				`NOV_THR0_OFS: thr_reg[0] <= wthr;
				`NOV_TIM0_OFS: tim_reg[0] <= wd[16:0];
				`NOV_THR1_OFS: thr_reg[1] <= wthr;
				`NOV_TIM1_OFS: tim_reg[1] <= wd[16:0];
				default: begin
					// Unmapped and read-only offsets ignore writes.
				end
			endcase
		end
	end

	// ==========================================================
	// Processing cycle: sample magnitude and block once per strobe
	// and evaluate the comparator on the sample latched at the previous strobe.
	// The outputs follow the next state on every enabled cycle, so
	// they trail a pick-up or block change by one clock.
	always @(posedge core_clk) begin
		if (rst) begin
			meas_reg    <= 17'h00000;
			block_reg   <= 1'b0;
			pickup_reg  <= 1'b0;
			stage_state <= ST_NORMAL;
			start_out   <= 1'b0;
			trip_out    <= 1'b0;
			blocked_out <= 1'b0;
		end else if (clk_en) begin
			if (cycle_strobe) begin
				meas_reg   <= meas_next;
				block_reg  <= block_in;
				pickup_reg <= pickup_next;
			end
			stage_state <= state_next;
			start_out   <= (state_next == ST_START) ||
			               (state_next == ST_TRIP);
			trip_out    <= (state_next == ST_TRIP);
			blocked_out <= (state_next == ST_BLOCKED);
		end
	end

	// ==========================================================
	// Time base. Elapsed time runs only while started; a release or
	// a block clears it, so the remaining time restarts cleanly.
	// The count stops at the longest time, so the remaining time
	// can never wrap back to a positive value.
	always @(posedge core_clk) begin
		if (rst) begin
			tick_reg <= 16'h0000;
			elap_reg <= 19'h00000;
		end else if (clk_en) begin
			if (!start_out) begin
				tick_reg <= 16'h0000;
				elap_reg <= 19'h00000;
			end else if (tick_reg == STEP_CYC[15:0] - 16'h0001) begin
				tick_reg <= 16'h0000;
				if (elap_reg != `NOV_TIME_MAX) begin
					elap_reg <= elap_reg + 19'h00001;
				end
			end else begin
				tick_reg <= tick_reg + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Shared serial divider, run after each strobe: first the ratio,
	// then the inverse-time figure. One divider keeps area small at
	// the cost of results lagging the strobe by about 70 cycles.
	always @(posedge core_clk) begin
		if (rst) begin
			dv_state_reg <= DV_IDLE;
			dv_cnt_reg   <= 6'h00;
			dv_num_reg   <= 32'h00000000;
			dv_den_reg   <= 32'h00000000;
			dv_rem_reg   <= 32'h00000000;
			dv_quo_reg   <= 32'h00000000;
			ratio_reg    <= 17'h00000;
			expt_reg     <= 19'h00000;
		end else if (clk_en) begin
			if (dv_state_reg != DV_IDLE && dv_cnt_reg != 6'h20) begin
				// One restoring step per clock.
				dv_num_reg <= {dv_num_reg[30:0], 1'b0};
				dv_cnt_reg <= dv_cnt_reg + 6'h01;
				if (rem_sh >= dv_den_reg) begin
					dv_rem_reg <= rem_sh - dv_den_reg;
					dv_quo_reg <= {dv_quo_reg[30:0], 1'b1};
				end else begin
					dv_rem_reg <= rem_sh;
					dv_quo_reg <= {dv_quo_reg[30:0], 1'b0};
				end
			end else begin
				case (dv_state_reg)
					DV_IDLE: begin
						// Start just after the strobe, on the new sample.
						if (cycle_strobe) begin
							dv_state_reg <= DV_RATIO;
						end
						dv_num_reg <= {8'h00, mn100};
						dv_den_reg <= {18'h0, thr_act};
						dv_cnt_reg <= 6'h00;
						dv_rem_reg <= 32'h00000000;
					end
					DV_RATIO: begin
						ratio_reg <= (dv_quo_reg > {15'h0, `NOV_RATIO_MAX})
						           ? `NOV_RATIO_MAX
						           : dv_quo_reg[16:0];
						// Inverse time with unit exponent, 5 ms steps:
						// k * 2 * threshold / (measured - threshold).
						dv_num_reg <= {tim_act[15:0], 1'b0} * thr_act;
						dv_den_reg <= {15'h0, meas_reg}
						            - {18'h0, thr_act};
						dv_cnt_reg <= 6'h00;
						dv_rem_reg <= 32'h00000000;
						dv_state_reg <= DV_TIME;
					end
					DV_TIME: begin
						dv_state_reg <= DV_IDLE;
						if (!inverse_time_mode) begin
							expt_reg <= {3'h0, tim_act[15:0]};
						end else if (meas_reg <= {3'h0, thr_act} ||
						  dv_quo_reg > {13'h0, `NOV_TIME_MAX}) begin
							expt_reg <= `NOV_TIME_MAX;
						end else begin
							expt_reg <= dv_quo_reg[18:0];
						end
					end
					default: dv_state_reg <= DV_IDLE;
				endcase
			end
		end
	end

endmodule // nov_stage

// *** verilog/nov_consts.vh ***
// Constants for the neutral overvoltage pick-up stage.
`ifndef NOV_CONSTS_VH
`define NOV_CONSTS_VH
// ==========================================================
// Register byte offsets.
`define NOV_CTRL_OFS   6'h00
`define NOV_THR0_OFS   6'h04
`define NOV_TIM0_OFS   6'h08
`define NOV_THR1_OFS   6'h0C
`define NOV_TIM1_OFS   6'h10
`define NOV_STAT_OFS   6'h14
`define NOV_RATIO_OFS  6'h18
`define NOV_EXPT_OFS   6'h1C
`define NOV_TREM_OFS   6'h20
// ==========================================================
// Field positions and reset values.
`define NOV_TIM_INVERSE_TIME_MODE_BIT 16
`define NOV_THR_RST    14'h07D0
`define NOV_THR_MIN    14'h0064
`define NOV_THR_MAX    14'h26AC
`define NOV_TIM_RST    17'h00008
// ==========================================================
// Scaling and clamps.
`define NOV_CALC_SCALE 16'h93CA
`define NOV_RATIO_MAX  17'h1E848
`define NOV_TIME_MAX   19'h57E40
`define NOV_REL_PCT    7'h61
`define NOV_HUNDRED    7'h64
// ==========================================================
// Timing: the 5 ms step, at a 10 MHz clock.
`define NOV_STEP_US    5000
`define NOV_CLK_KHZ    10000
`define NOV_STEP_CYC   (`NOV_STEP_US * `NOV_CLK_KHZ / 1000)
`endif

// *** bench/nov_stage_checker.sv ***
// Port assertions for the neutral overvoltage stage.
// ==========================================================
// Checker module.
module nov_stage_checker (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic [5:0]  avm_address,
	input wire logic        avm_read,
	input wire logic        avm_write,
	input wire logic [31:0] avm_readdata,
	input wire logic        avm_waitrequest,
	input wire logic [1:0]  stage_state,
	input wire logic        start_out,
	input wire logic        trip_out,
	input wire logic        blocked_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// A taken request is answered on the very next edge.
	bus_answer_a: assert property ((avm_read || avm_write) && clk_en &&
		avm_waitrequest |=> !avm_waitrequest) else $error("no answer");
	// The answer lasts exactly one cycle.
	wait_pulse_a: assert property (!avm_waitrequest && clk_en
		|=> avm_waitrequest) else $error("answer too long");
	// Read data stays put once handed over.
	rdata_hold_a: assert property (!avm_waitrequest && clk_en
		|=> $stable(avm_readdata)) else $error("read data moved");
	// Unmapped places read as zero.
	unmapped_zero_a: assert property (avm_read && avm_waitrequest &&
		clk_en && avm_address > 6'h20 |=> avm_readdata == 32'h0)
		else $error("unmapped read not zero");
	// Each stage state drives its own indication set.
	trip_flags_a: assert property (stage_state == 2'h2 |-> start_out &&
		trip_out && !blocked_out) else $error("trip flags");
	start_flags_a: assert property (stage_state == 2'h1 |-> start_out &&
		!trip_out && !blocked_out) else $error("start flags");
	block_flags_a: assert property (stage_state == 2'h3 |-> blocked_out &&
		!start_out && !trip_out) else $error("blocked flags");
	normal_flags_a: assert property (stage_state == 2'h0 |-> !start_out &&
		!trip_out && !blocked_out) else $error("normal flags");
	// Reset idles the bus and the stage.
	reset_idle_a: assert property (disable iff (1'b0) rst && clk_en
		|=> avm_waitrequest && stage_state == 2'h0) else $error("reset");
endmodule // nov_stage_checker

bind nov_stage nov_stage_checker nov_stage_checker_inst (.core_clk,
	.rst, .clk_en, .avm_address, .avm_read, .avm_write, .avm_readdata,
	.avm_waitrequest, .stage_state, .start_out, .trip_out, .blocked_out);

// *** bench/nov_meas_model.sv ***
// Measurement front end model: magnitudes and processing cycle strobe.
// ==========================================================
// Model module.
module nov_meas_model #(
	parameter PERIOD = 100 // Cycles per processing cycle.
) (
	input wire logic         core_clk,
	input wire logic         rst,
	input wire logic  [15:0] ul_set,
	input wire logic  [15:0] ch3_set,
	input wire logic  [15:0] ch4_set,
	output logic             cycle_strobe,
	output logic      [15:0] ul1_mag,
	output logic      [15:0] ul2_mag,
	output logic      [15:0] ul3_mag,
	output logic      [15:0] ch3_mag,
	output logic      [15:0] ch4_mag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt; // Position inside the processing cycle.
	// New magnitudes land on the same edge that raises the strobe, so the stage
	// never samples a value that is still changing.
	always @(posedge core_clk) begin
		if (rst) begin
			cnt <= 8'h00;
			cycle_strobe <= 1'b0;
		end else begin
			cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
			cycle_strobe <= (cnt == 8'h00);
		end
		if (rst || cnt == 8'h00) begin
			ul1_mag <= ul_set;
			ul2_mag <= ul_set;
			ul3_mag <= ul_set;
			ch3_mag <= ch3_set;
			ch4_mag <= ch4_set;
		end
	end
endmodule // nov_meas_model

// *** bench/tb_neutral_overvoltage_pickup.sv ***
// Self-checking testbench for the neutral overvoltage stage.
module tb_neutral_overvoltage_pickup;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals.
	logic        core_clk = 0, rst = 1, clk_en = 1;
	logic        avm_read = 0, avm_write = 0, avm_waitrequest;
	logic [5:0]  avm_address = 0;
	logic [31:0] avm_writedata = 0, avm_readdata, rd;
	logic        cycle_strobe, start_out, trip_out, blocked_out;
	logic [1:0]  stage_state;
	logic [15:0] ul1_mag, ul2_mag, ul3_mag, ch3_mag, ch4_mag;
	logic [15:0] ul_set = 0, ch3_set = 0, ch4_set = 0;
	logic        ch3_resid_mode = 0, ch4_resid_mode = 0, ln_connected = 0;
	logic        force_enable = 0, group_sel = 0, block_in = 0;
	integer      fail_count = 0, checks = 0, cyc = 0, n, s;
	always #50 core_clk = ~core_clk;
	// ==========================================================
	// Instances; the step count is shortened to keep the run brief.
	nov_stage #(.STEP_CYC(4)) nov_stage_inst (.core_clk, .rst, .clk_en,
		.avm_address, .avm_read, .avm_write, .avm_writedata, .avm_readdata,
		.avm_waitrequest, .cycle_strobe, .ul1_mag, .ul2_mag, .ul3_mag,
		.ch3_mag, .ch4_mag, .ch3_resid_mode, .ch4_resid_mode, .ln_connected,
		.force_enable, .group_sel, .block_in, .stage_state, .start_out,
		.trip_out, .blocked_out);
	nov_meas_model #(.PERIOD(100)) nov_meas_model_inst (.core_clk, .rst,
		.ul_set, .ch3_set, .ch4_set, .cycle_strobe, .ul1_mag,
		.ul2_mag, .ul3_mag, .ch3_mag, .ch4_mag);
	// ==========================================================
	// Tasks.
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One bus access, held until waitrequest is seen low at an edge.
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		avm_address <= a;
		avm_writedata <= d;
		avm_write <= w;
		avm_read <= !w;
		@(posedge core_clk);
		while (avm_waitrequest !== 1'b0) @(posedge core_clk);
		rd = avm_readdata;
		avm_write <= 1'b0;
		avm_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task rdf(input logic [5:0] a, input int sh, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, (rd >> sh) & m);
	endtask
	// Two strobes plus divider time cover the measurement lag.
	task settle;
		repeat (380) @(posedge core_clk);
	endtask
	// Hang guard: the sequence needs well under this many cycles.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test;
		end
	end
	// ==========================================================
	// Main sequence.
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rdf(6'h00, 0, 32'hF, 32'h0, "ctrl reset");
		rdf(6'h04, 0, 32'h3FFF, 32'h7D0, "thr0 reset");
		rdf(6'h0C, 0, 32'h3FFF, 32'h7D0, "thr1 reset");
		rdf(6'h08, 0, 32'h1FFFF, 32'h8, "tim0 reset");
		rdf(6'h24, 0, 32'hFFFFFFFF, 32'h0, "unmapped");
		bus(1'b1, 6'h04, 32'h32);
		rdf(6'h04, 0, 32'h3FFF, 32'h64, "thr clamp");
		bus(1'b1, 6'h04, 32'h7D0);
		ln_connected <= 1'b1;
		settle;
		rdf(6'h14, 0, 32'h3, 32'h1, "fallback src");
		ln_connected <= 1'b0;
		settle;
		rdf(6'h14, 0, 32'h3, 32'h0, "no residual");
		bus(1'b1, 6'h00, 32'h2);
		rdf(6'h00, 0, 32'h3, 32'h0, "ch3 refused");
		ch3_resid_mode <= 1'b1;
		ch4_resid_mode <= 1'b1;
		ln_connected <= 1'b1;
		ch4_set <= 16'd1000;
		// Each source code from 1 to 3 shows up as the active source.
		for (s = 1; s < 4; s++) begin
			bus(1'b1, 6'h00, 32'(s));
			settle;
			rdf(6'h14, 0, 32'h3, 32'(s), "active src");
		end
		rdf(6'h18, 0, 32'h1FFFF, 32'd50, "ch4 ratio");
		bus(1'b1, 6'h00, 32'h1);
		ul_set <= 16'd5774;
		settle;
		rdf(6'h18, 0, 32'h1FFFF, 32'd500, "calc ratio");
		rdf(6'h14, 2, 32'h1, 32'h1, "calc pickup");
		ul_set <= 16'd0;
		settle;
		rdf(6'h14, 2, 32'h1, 32'h0, "calc release");
		ch3_set <= 16'd2000;
		bus(1'b1, 6'h00, 32'h2);
		settle;
		rdf(6'h14, 2, 32'h1, 32'h0, "equal no pickup");
		ch3_set <= 16'd3000;
		n = 0;
		while (start_out !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		n = 0;
		while (trip_out !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		chk("dt delay", 32'h1, 32'(n >= 30 && n <= 40));
		settle;
		bus(1'b1, 6'h18, 32'h0);
		rdf(6'h18, 0, 32'h1FFFF, 32'd150, "ratio");
		rdf(6'h1C, 0, 32'h7FFFF, 32'd8, "dt expt");
		rdf(6'h20, 31, 32'h1, 32'h1, "trem sign");
		chk("trip out", 32'h1, 32'(trip_out));
		ch3_set <= 16'd1950;
		settle;
		rdf(6'h14, 2, 32'h1, 32'h1, "hold band");
		ch3_set <= 16'd1939;
		settle;
		rdf(6'h14, 2, 32'h1, 32'h0, "release");
		bus(1'b1, 6'h08, 32'h10005);
		ch3_set <= 16'd3000;
		settle;
		rdf(6'h1C, 0, 32'h7FFFF, 32'd20, "inv expt 1");
		ch3_set <= 16'd4000;
		settle;
		rdf(6'h1C, 0, 32'h7FFFF, 32'd10, "inv expt 2");
		bus(1'b1, 6'h0C, 32'hDAC);
		group_sel <= 1'b1;
		ch3_set <= 16'd3000;
		settle;
		rdf(6'h14, 2, 32'h1, 32'h0, "group1 thr");
		rdf(6'h00, 0, 32'h3, 32'h2, "src static");
		group_sel <= 1'b0;
		settle;
		rdf(6'h14, 2, 32'h1, 32'h1, "group0 thr");
		block_in <= 1'b1;
		settle;
		chk("blocked", 32'h3, 32'(stage_state));
		chk("blocked out", 32'h1, 32'(blocked_out));
		block_in <= 1'b0;
		ch3_set <= 16'd1000;
		bus(1'b1, 6'h00, 32'hA);
		settle;
		chk("force off", 32'h0, 32'(stage_state));
		force_enable <= 1'b1;
		// Every forced status is honoured once forcing is allowed.
		for (s = 1; s < 4; s++) begin
			bus(1'b1, 6'h00, 32'((s << 2) | 2));
			settle;
			chk("forced", 32'(s), 32'(stage_state));
		end
		// A low clock enable freezes the stage output in place.
		clk_en <= 1'b0;
		force_enable <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk("frozen", 32'h3, 32'(stage_state));
		clk_en <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("thawed", 32'h0, 32'(stage_state));
		end_of_test;
	end
endmodule // tb_neutral_overvoltage_pickup
